// ==== design/shmu_defs.svh ====
// Constants of the signed halfword and word multiply unit
`ifndef SHMU_DEFS_SVH
`define SHMU_DEFS_SVH
`define SHMU_HALF_LO_MSB  15
`define SHMU_HALF_HI_LSB  16
`define SHMU_ROUND_CONST  64'h0000_0000_8000_0000
`define SHMU_RESULT_RESET 64'h0
`define SHMU_LATENCY      2
`endif

// ==== design/shmu_half_mul.sv ====
// Two signed 16x16 halfword multipliers with optional cross
`timescale 1ns/1ps
`include "shmu_defs.svh"
module shmu_half_mul
  import shmu_pkg::*;
(
  input  wire logic [31:0] a,       // First operand
  input  wire logic [31:0] b,       // Second operand
  input  wire logic        swap,    // Cross halfwords of b
  output logic      [31:0] prod_lo, // Bottom product
  output logic      [31:0] prod_hi  // Top product
);
  logic [31:0] b_sel;               // Possibly exchanged b
  logic [31:0] a_lo;                // Sign extended bottom half of a
  logic [31:0] a_hi;                // Sign extended top half of a
  logic [31:0] b_lo;                // Sign extended bottom half of b_sel
  logic [31:0] b_hi;                // Sign extended top half of b_sel
  // Exchange halfwords of the second operand
  assign b_sel = swap ? {b[`SHMU_HALF_LO_MSB:0], b[31:`SHMU_HALF_HI_LSB]} : b;
  // Widen halves first so the product is formed at full 32-bit width
  assign a_lo = {{16{a[`SHMU_HALF_LO_MSB]}}, a[`SHMU_HALF_LO_MSB:0]};
  assign a_hi = {{16{a[31]}}, a[31:`SHMU_HALF_HI_LSB]};
  assign b_lo = {{16{b_sel[`SHMU_HALF_LO_MSB]}}, b_sel[`SHMU_HALF_LO_MSB:0]};
  assign b_hi = {{16{b_sel[31]}}, b_sel[31:`SHMU_HALF_HI_LSB]};
  // Signed products, cannot overflow 32 bits
  assign prod_lo = a_lo * b_lo;
  assign prod_hi = a_hi * b_hi;
endmodule

// ==== design/shmu_pkg.sv ====
// Types of the signed halfword and word multiply unit
package shmu_pkg;
  // Operation codes, one-hot
  typedef enum logic [6:0] {
    SHMU_OP_DUAL_SUB_ACC  = 7'h01,
    SHMU_OP_DUAL_SUB_LONG = 7'h02,
    SHMU_OP_UPPER_ACC     = 7'h04,
    SHMU_OP_UPPER_SUB     = 7'h08,
    SHMU_OP_UPPER_MUL     = 7'h10,
    SHMU_OP_DUAL_ADD      = 7'h20,
    SHMU_OP_DUAL_DIFF     = 7'h40
  } shmu_op_t;
  // Request from decode
  typedef struct packed {
    shmu_op_t    op;
    logic        swap;
    logic        round;
    logic [31:0] first_operand;
    logic [31:0] second_operand;
    logic [31:0] accum_operand;
    logic [31:0] long_upper_half;
    logic [31:0] long_lower_half;
  } shmu_req_t;
  // Result to register file
  typedef struct packed {
    logic [31:0] long_upper_half;
    logic [31:0] result;
    logic        is_long;
    logic        sat;
  } shmu_res_t;
endpackage

// ==== design/shmu_top.sv ====
// Signed multiply datapath: dual halfword and upper word forms
`timescale 1ns/1ps
`include "shmu_defs.svh"
module shmu_top
  import shmu_pkg::*;
(
  input  wire logic      clk,        // 40 MHz clock
  input  wire logic      rst,        // Sync reset, active high
  input  wire logic      req_valid,  // Request strobe
  input  wire shmu_req_t req,        // Operation and operands
  output shmu_res_t      res,        // Registered result
  output logic           res_valid,  // Result strobe, one cycle
  output logic           sticky_sat, // Sticky saturation flag
  output logic           flags_we    // Condition flag write, held low
);
  logic [31:0] prod_lo;              // Bottom halfword product
  logic [31:0] prod_hi;              // Top halfword product
  logic [31:0] upper;                // Upper product word
  logic [63:0] next_wide;            // Next 64-bit result
  logic        next_sat;             // Overflow of this operation
  logic        next_long;            // Writes a register pair
  logic [31:0] diff;                 // Bottom minus top product
  logic [32:0] sum33;                // Widened sum for overflow
  logic [31:0] acc_sum;              // 32-bit accumulate result

  // Halfword multiplier pair
  shmu_half_mul u_half (
    .a       (req.first_operand),
    .b       (req.second_operand),
    .swap    (req.swap),
    .prod_lo (prod_lo),
    .prod_hi (prod_hi)
  );

  // Upper word multiplier
  shmu_word_mul u_word (
    .a     (req.first_operand),
    .b     (req.second_operand),
    .round (req.round),
    .upper (upper)
  );

  // Signed overflow of a 32-bit addition
  function automatic logic add_ovf(input logic [31:0] x, input logic [31:0] y,
                                   input logic [31:0] s);
    add_ovf = (x[31] == y[31]) && (s[31] != x[31]);
  endfunction

  // Difference never overflows
  assign diff    = prod_lo - prod_hi;
  assign acc_sum = diff + req.accum_operand;
  assign sum33   = {prod_lo[31], prod_lo} + {prod_hi[31], prod_hi};

  // Result selection per operation
  always_comb begin
    next_wide = `SHMU_RESULT_RESET;
    next_sat  = 1'b0;
    next_long = 1'b0;
    case (req.op)
      SHMU_OP_DUAL_SUB_ACC: begin
        // Difference plus accumulate, wraps
        next_wide = {32'h0, acc_sum};
        next_sat  = add_ovf(diff, req.accum_operand, acc_sum);
      end
      SHMU_OP_DUAL_SUB_LONG: begin
        // Sign extended difference plus register pair
        next_wide = {{32{diff[31]}}, diff} + {req.long_upper_half, req.long_lower_half};
        next_long = 1'b1;
      end
      SHMU_OP_UPPER_ACC: begin
        next_wide = {32'h0, upper + req.accum_operand};
      end
      SHMU_OP_UPPER_SUB: begin
        next_wide = {32'h0, req.accum_operand - upper};
      end
      SHMU_OP_UPPER_MUL: begin
        next_wide = {32'h0, upper};
      end
      SHMU_OP_DUAL_ADD: begin
        // Sum of products, overflow past 32 bits flagged
        next_wide = {32'h0, sum33[31:0]};
        next_sat  = sum33[32] != sum33[31];
      end
      SHMU_OP_DUAL_DIFF: begin
        next_wide = {32'h0, diff};
      end
      default: begin
        next_wide = `SHMU_RESULT_RESET;
      end
    endcase
  end

  // Result register
  always_ff @(posedge clk) begin
    if (rst) begin
      res       <= '0;
      res_valid <= 1'b0;
    end else begin
      res_valid <= req_valid;
      if (req_valid) begin
        res.long_upper_half <= next_wide[63:32];
        res.result          <= next_wide[31:0];
        res.is_long         <= next_long;
        res.sat             <= next_sat;
      end
    end
  end

  // Sticky flag: only set here, cleared only by reset
  always_ff @(posedge clk) begin
    if (rst) begin
      sticky_sat <= 1'b0;
    end else if (req_valid && next_sat) begin
      sticky_sat <= 1'b1;
    end
  end

  // No operation here writes condition flags
  always_ff @(posedge clk) begin
    if (rst) begin
      flags_we <= 1'b0;
    end else begin
      flags_we <= 1'b0;
    end
  end

  // Sticky flag rises one cycle after a saturating request
  AST_SAT_SET: assert property (@(posedge clk) disable iff (rst)
    req_valid && next_sat |=> sticky_sat) else $error("sat not set");
  // Sticky flag never falls outside reset
  AST_SAT_STICKY: assert property (@(posedge clk) disable iff (rst)
    sticky_sat |=> sticky_sat) else $error("sat cleared");
  // Flag write stays low
  AST_NO_FLAGS: assert property (@(posedge clk) disable iff (rst)
    !flags_we) else $error("flags written");
  // Result strobe follows request by one cycle
  AST_VALID: assert property (@(posedge clk) disable iff (rst)
    req_valid |=> res_valid) else $error("no result");
  // Dual add result is wrapped sum
  AST_DUAL_ADD: assert property (@(posedge clk) disable iff (rst)
    req_valid && req.op == SHMU_OP_DUAL_ADD |=>
    res.result == $past(prod_lo) + $past(prod_hi)) else $error("dual add");
  // Upper subtract result
  AST_UPPER_SUB: assert property (@(posedge clk) disable iff (rst)
    req_valid && req.op == SHMU_OP_UPPER_SUB |=>
    res.result == $past(req.accum_operand) - $past(upper)) else $error("upper sub");
  // Long form marks pair write
  AST_LONG: assert property (@(posedge clk) disable iff (rst)
    req_valid && req.op == SHMU_OP_DUAL_SUB_LONG |=> res.is_long) else $error("long");
  // Upper word multiply only
  AST_UPPER_MUL: assert property (@(posedge clk) disable iff (rst)
    req_valid && req.op == SHMU_OP_UPPER_MUL |=>
    res.result == $past(upper) && !res.sat) else $error("upper mul");
endmodule

// ==== design/shmu_word_mul.sv ====
// Signed 32x32 multiplier giving the upper word, optionally rounded
`timescale 1ns/1ps
`include "shmu_defs.svh"
module shmu_word_mul
  import shmu_pkg::*;
(
  input  wire logic [31:0] a,     // First operand
  input  wire logic [31:0] b,     // Second operand
  input  wire logic        round, // Add rounding constant
  output logic      [31:0] upper  // Upper product word
);
  logic [63:0] prod;              // Full signed product
  logic [63:0] adj;               // Rounded or truncated product
  logic [63:0] a_ext;             // Sign extended a
  logic [63:0] b_ext;             // Sign extended b
  // Widen before multiplying so no upper bits are lost to a narrow context
  assign a_ext = {{32{a[31]}}, a};
  assign b_ext = {{32{b[31]}}, b};
  assign prod  = a_ext * b_ext;
  // Rounding constant added before taking upper word
  assign adj   = round ? prod + `SHMU_ROUND_CONST : prod;
  assign upper = adj[63:32];
endmodule

// ==== test/shmu_decode_model.sv ====
// Decode and register file model that feeds the multiply unit
`timescale 1ns/1ps
module shmu_decode_model
  import shmu_pkg::*;
(
  input  wire logic clk,       // Core clock
  output logic      req_valid, // Request strobe
  output shmu_req_t req        // Operation and operands
);
  // Idle at time zero
  initial begin
    req_valid = 1'b0;
    req = '0;
  end
  // Present one request and hold it over the taking edge
  task automatic send(input shmu_req_t r);
    req_valid = 1'b1;
    req = r;
    @(posedge clk);
    #1;
  endtask
  // Release the strobe; released operands show garbage
  task automatic idle();
    req_valid = 1'b0;
    req = ~req;
  endtask
endmodule

// ==== test/tb_shmu_top.sv ====
// Self-checking bench of the multiply unit
`timescale 1ns/1ps
module tb_shmu_top import shmu_pkg::*; ;
  logic      clk = 1'b0; // Bench clock
  logic      rst = 1'b1; // Reset
  logic      req_valid;  // From model
  shmu_req_t req;        // From model
  shmu_res_t res;        // Result
  logic      res_valid;  // Result strobe
  logic      sticky_sat; // Sticky flag
  logic      flags_we;   // Flag write
  logic      exp_sticky; // Expected sticky flag
  int        n_fail = 0;
  int        checks_done = 0;
  // Operand rows: first, second, accumulate, pair upper, pair lower
  logic [159:0] rows [4] = '{
    {32'h0003_fffe, 32'h0005_0007, 32'h0000_0010, 32'hffff_ffff, 32'h0000_0001},
    {32'h8000_8000, 32'h8000_7fff, 32'h7fff_fff0, 32'h0000_0000, 32'hffff_fff0},
    {32'h7fff_ffff, 32'h8000_0001, 32'h8000_0000, 32'h7fff_ffff, 32'hffff_ffff},
    {32'h1234_5678, 32'hffff_8765, 32'h0000_0000, 32'h8000_0000, 32'h0000_0000}};
  always #12.5 clk = ~clk;
  shmu_decode_model model (.clk(clk), .req_valid(req_valid), .req(req));
  shmu_top uut (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req), .res(res),
                .res_valid(res_valid), .sticky_sat(sticky_sat), .flags_we(flags_we));
  // Reference result of one request
  function automatic shmu_res_t expect_of(shmu_req_t q);
    shmu_res_t          e;
    logic [31:0]        b, d, s;
    logic signed [31:0] p0, p1;
    logic signed [63:0] w;
    e = '0;
    b = q.swap ? {q.second_operand[15:0], q.second_operand[31:16]} : q.second_operand;
    p0 = $signed(q.first_operand[15:0]) * $signed(b[15:0]);
    p1 = $signed(q.first_operand[31:16]) * $signed(b[31:16]);
    w = $signed(q.first_operand) * $signed(q.second_operand) + (q.round ? 64'sh8000_0000 : 64'sh0);
    d = p0 - p1;
    s = p0 + p1;
    case (q.op)
      SHMU_OP_DUAL_SUB_ACC: begin
        e.result = d + q.accum_operand;
        e.sat = (d[31] == q.accum_operand[31]) && (e.result[31] != d[31]);
      end
      SHMU_OP_DUAL_SUB_LONG: begin
        {e.long_upper_half, e.result} = {q.long_upper_half, q.long_lower_half} + {{32{d[31]}}, d};
        e.is_long = 1'b1;
      end
      SHMU_OP_UPPER_ACC: e.result = q.accum_operand + w[63:32];
      SHMU_OP_UPPER_SUB: e.result = q.accum_operand - w[63:32];
      SHMU_OP_UPPER_MUL: e.result = w[63:32];
      SHMU_OP_DUAL_ADD: begin
        e.result = s;
        e.sat = (p0[31] == p1[31]) && (s[31] != p0[31]);
      end
      SHMU_OP_DUAL_DIFF: e.result = d;
      default: e = '0;
    endcase
    return e;
  endfunction
  // Compare a result word
  task automatic check_res(input shmu_res_t got, input shmu_res_t want);
    checks_done++;
    if (got !== want) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  // Compare a single flag
  task automatic check_bit(input logic got, input logic want);
    checks_done++;
    if (got !== want) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  // Issue one request and check the answer one cycle later
  task automatic run_op(input shmu_req_t q);
    shmu_res_t e;
    e = expect_of(q);
    model.send(q);
    exp_sticky = exp_sticky | e.sat;
    check_res(res, e);
    check_bit(res_valid, 1'b1);
    check_bit(sticky_sat, exp_sticky);
    check_bit(flags_we, 1'b0);
  endtask
  // Print counts and verdict, then stop
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    exp_sticky = 1'b0;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    // Every operation, option off and on, back to back over all rows
    for (int i = 0; i < 4; i++)
      for (int k = 0; k < 7; k++)
        for (int f = 0; f < 2; f++)
          run_op('{shmu_op_t'(7'h01 << k), f[0], f[0], rows[i][159:128], rows[i][127:96],
                   rows[i][95:64], rows[i][63:32], rows[i][31:0]});
    model.idle();
    @(posedge clk);
    #1 check_bit(res_valid, 1'b0);
    $display("table done");
    // Mid-run reset clears the sticky flag and the result
    rst = 1'b1;
    @(posedge clk);
    #1 rst = 1'b0;
    exp_sticky = 1'b0;
    check_bit(sticky_sat, 1'b0);
    check_res(res, '0);
    // Overflow of the dual add, then a clean operation keeps the flag
    run_op('{SHMU_OP_DUAL_ADD, 1'b0, 1'b0, 32'h8000_8000, 32'h8000_8000, 32'h0, 32'h0, 32'h0});
    run_op('{SHMU_OP_DUAL_DIFF, 1'b1, 1'b0, 32'h0001_0002, 32'h0003_0004, 32'h0, 32'h0, 32'h0});
    run_op('{shmu_op_t'(7'h03), 1'b0, 1'b0, 32'h1, 32'h1, 32'h1, 32'h1, 32'h1});
    model.idle();
    $display("awkward cases done");
    print_verdict();
  end
endmodule
